// ### include/cfr_pkg.sv
// Purpose: shared constants for the filter routing control bank
// Assumes: 32-bit APB register words, one aligned word per register
// Notes:   filters 4 to 15, four filters per control word

// ============================================================
// package
package cfr_pkg;

  // bank geometry
  localparam int          CFR_FIRST_FILTER  = 4;
  localparam int          CFR_NUM_FILTERS   = 12;
  localparam int          CFR_LANES_PER_REG = 4;
  localparam int          CFR_NUM_CTRL_REGS = 3;
  localparam int          CFR_PTR_W         = 5;

  // register byte offsets
  localparam logic [11:0] CFR_OFS_ROUTE_4_TO_7   = 12'h000;
  localparam logic [11:0] CFR_OFS_ROUTE_8_TO_11  = 12'h004;
  localparam logic [11:0] CFR_OFS_ROUTE_12_TO_15 = 12'h008;
  localparam logic [11:0] CFR_OFS_ROUTE_STATUS   = 12'h00c;

  // field positions inside one filter byte lane
  localparam int          CFR_EN_BIT        = 7;
  localparam int          CFR_PTR_LSB       = 0;

  // field positions inside the status word
  localparam int          CFR_STAT_EN_LSB   = 0;
  localparam int          CFR_STAT_REJ_BIT  = 16;
  localparam int          CFR_STAT_ZERO_BIT = 17;
  localparam int          CFR_STAT_REJ_LANE = 2;

  // values after reset, and the reserved pointer value
  localparam logic [31:0] CFR_CTRL_RESET    = 32'h0000_0000;
  localparam logic        CFR_EN_RESET      = 1'h0;
  localparam logic [4:0]  CFR_PTR_RESET     = 5'h00;
  localparam logic [4:0]  CFR_PTR_RESERVED  = 5'h00;

  // register select decode
  typedef enum logic [2:0] {
    CFR_SEL_CTRL0,
    CFR_SEL_CTRL1,
    CFR_SEL_CTRL2,
    CFR_SEL_STATUS,
    CFR_SEL_NONE
  } cfr_sel_t;

endpackage

// ### logic/cfr_filter_lane.sv
// Purpose: enable bit and destination pointer of one acceptance filter
// Assumes: wrEn is a one-cycle strobe at the committing bus edge
// Notes:   bits 6:5 of the written byte are not stored

`timescale 1ns/1ps

// ============================================================
// filter lane
module cfr_filter_lane
  import cfr_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // write side
  input  wire logic       wrEn,
  input  wire logic [7:0] wrByte,
  // state
  output logic            acceptOn,
  output logic [4:0]      destObject,
  output logic            ptrReject,
  output logic            zeroTarget
);

  logic       en_r;
  logic [4:0] ptr_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      en_r <= CFR_EN_RESET;
    end else if (wrEn) begin
      en_r <= wrByte[CFR_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_r <= CFR_PTR_RESET;
    end else if (wrEn && !en_r) begin
      ptr_r <= wrByte[CFR_PTR_LSB +: CFR_PTR_W];
    end
  end

  assign ptrReject  = wrEn && en_r && (wrByte[CFR_PTR_LSB +: CFR_PTR_W] != ptr_r);
  assign zeroTarget = en_r && (ptr_r == CFR_PTR_RESERVED);
  assign acceptOn   = en_r;
  assign destObject = ptr_r;

endmodule // cfr_filter_lane

// ### logic/cfr_route_bank.sv
// Purpose: APB control bank routing filters 4 to 15 to receive objects
// Assumes: APB with pstrb; zero wait states; synchronous reset
// Notes:   outputs feed the acceptance and storage logic of the controller
//
// Local design decisions: the APB slave port and the address map.

`timescale 1ns/1ps

// ============================================================
// route bank
module cfr_route_bank
  import cfr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // apb slave
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // routing to acceptance logic
  output logic      [CFR_NUM_FILTERS-1:0]   filterAcceptOn,
  output logic      [CFR_NUM_FILTERS*5-1:0] filterDestObject
);

  // ============================================================
  // address decode
  function automatic cfr_sel_t decodeSel(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    if (ADDR_W > 12 && (addr >> 12) != '0) begin
      decodeSel = CFR_SEL_NONE;
    end else begin
      case (a)
        CFR_OFS_ROUTE_4_TO_7:   decodeSel = CFR_SEL_CTRL0;
        CFR_OFS_ROUTE_8_TO_11:  decodeSel = CFR_SEL_CTRL1;
        CFR_OFS_ROUTE_12_TO_15: decodeSel = CFR_SEL_CTRL2;
        CFR_OFS_ROUTE_STATUS:   decodeSel = CFR_SEL_STATUS;
        default:                decodeSel = CFR_SEL_NONE;
      endcase
    end
  endfunction

  // ============================================================
  // bus phases
  logic                       pready_r;
  logic                       pslverr_r;
  logic [31:0]                prdata_r;
  logic                       setupPhase;
  logic                       commit;
  logic                       wrCommit;
  cfr_sel_t                   sel;

  assign setupPhase = psel && !penable;
  assign commit     = psel && penable && pready_r;
  assign wrCommit   = commit && pwrite && !pslverr_r;
  assign sel        = decodeSel(paddr);

  // one-cycle access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_r <= 1'h0;
    end else begin
      pready_r <= setupPhase;
    end
  end

  // unmapped address answers with an error
  always_ff @(posedge clk) begin
    if (rst) begin
      pslverr_r <= 1'h0;
    end else if (setupPhase) begin
      pslverr_r <= (sel == CFR_SEL_NONE);
    end else if (commit) begin
      pslverr_r <= 1'h0;
    end
  end

  // ============================================================
  // filter lanes
  logic [CFR_NUM_FILTERS-1:0]   laneEn;
  logic [CFR_NUM_FILTERS*5-1:0] lanePtr;
  logic [CFR_NUM_FILTERS-1:0]   laneWr;
  logic [CFR_NUM_FILTERS-1:0]   laneReject;
  logic [CFR_NUM_FILTERS-1:0]   laneZero;
  logic [CFR_NUM_FILTERS*8-1:0] ctrlFlat;

  genvar gi;
  generate
    for (gi = 0; gi < CFR_NUM_FILTERS; gi++) begin : g_lane
      localparam int REG_IDX  = gi / CFR_LANES_PER_REG;
      localparam int LANE_IDX = gi % CFR_LANES_PER_REG;

      // word and byte lane of this filter
      assign laneWr[gi] = wrCommit && (sel == cfr_sel_t'(REG_IDX)) && pstrb[LANE_IDX];

      cfr_filter_lane u_lane (
        .clk        (clk),
        .rst        (rst),
        .wrEn       (laneWr[gi]),
        .wrByte     (pwdata[8*LANE_IDX +: 8]),
        .acceptOn   (laneEn[gi]),
        .destObject (lanePtr[5*gi +: 5]),
        .ptrReject  (laneReject[gi]),
        .zeroTarget (laneZero[gi])
      );

      assign ctrlFlat[8*gi +: 8] = {laneEn[gi], 2'h0, lanePtr[5*gi +: 5]};
    end
  endgenerate

  // ============================================================
  // status
  logic rejectSticky_r;
  logic rejectClear;
  logic zeroTarget_r;

  assign rejectClear = wrCommit && (sel == CFR_SEL_STATUS)
                       && pstrb[CFR_STAT_REJ_LANE] && pwdata[CFR_STAT_REJ_BIT];

  // sticky refused change, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      rejectSticky_r <= 1'h0;
    end else if (|laneReject) begin
      rejectSticky_r <= 1'h1;
    end else if (rejectClear) begin
      rejectSticky_r <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zeroTarget_r <= 1'h0;
    end else begin
      zeroTarget_r <= |laneZero;
    end
  end

  // ============================================================
  // read data
  logic [31:0] statusWord;
  logic [31:0] rdValue;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[CFR_STAT_EN_LSB +: CFR_NUM_FILTERS] = laneEn;
    statusWord[CFR_STAT_REJ_BIT]  = rejectSticky_r;
    statusWord[CFR_STAT_ZERO_BIT] = zeroTarget_r;
  end

  always_comb begin
    case (sel)
      CFR_SEL_CTRL0:  rdValue = ctrlFlat[0  +: 32];
      CFR_SEL_CTRL1:  rdValue = ctrlFlat[32 +: 32];
      CFR_SEL_CTRL2:  rdValue = ctrlFlat[64 +: 32];
      CFR_SEL_STATUS: rdValue = statusWord;
      default:        rdValue = CFR_CTRL_RESET;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPhase && !pwrite) begin
      prdata_r <= rdValue;
    end else if (commit) begin
      prdata_r <= 32'h0000_0000;
    end
  end

  // ============================================================
  // outputs
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  assign filterAcceptOn   = laneEn;
  assign filterDestObject = lanePtr;

endmodule // cfr_route_bank

// ### tb/cfr_route_asserts.sv
// Purpose: port assertions for the filter routing bank
// Assumes: zero wait state apb, synchronous reset
// Notes:   bound to cfr_route_bank
`timescale 1ns/1ps
// ============================================================
// checker
module cfr_route_asserts
  import cfr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // apb
  input wire logic [ADDR_W-1:0]          paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // routing
  input wire logic [CFR_NUM_FILTERS-1:0] filterAcceptOn,
  input wire logic [59:0]                filterDestObject
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wrDone = psel && penable && pready && pwrite;
  wire logic rdDone = pready && !pwrite;
  wire logic wr0    = wrDone && paddr == 'h0 && pstrb[0];

  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> filterAcceptOn == '0 && filterDestObject == '0) else $error("reset left state");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no access answer");
  a_enable_follows: assert property (wr0 |=> filterAcceptOn[0] == $past(pwdata[7]))
    else $error("enable not stored");
  a_ptr_when_idle: assert property (wr0 && !filterAcceptOn[0]
    |=> filterDestObject[4:0] == $past(pwdata[4:0])) else $error("pointer not stored");
  a_top_lane_map: assert property (wrDone && paddr == 'h8 && pstrb[3] && !filterAcceptOn[11]
    |=> filterDestObject[59:55] == $past(pwdata[28:24])) else $error("lane map wrong");
  a_ptr_locked: assert property (filterAcceptOn[0] |=> $stable(filterDestObject[4:0]))
    else $error("pointer moved while enabled");
  a_gap_reads_zero: assert property (rdDone && paddr < 'hc |-> (prdata & 32'h6060_6060) == '0)
    else $error("gap bits read nonzero");
  a_read_matches: assert property (rdDone && paddr == 'h0
    |-> prdata[7] == filterAcceptOn[0] && prdata[4:0] == filterDestObject[4:0])
    else $error("readback differs");

  c_write: cover property (wr0);
  c_read: cover property (rdDone);
  c_locked: cover property (wr0 && filterAcceptOn[0] && pwdata[4:0] != filterDestObject[4:0]);
  c_status: cover property (rdDone && paddr == 'hc);
endmodule // cfr_route_asserts

bind cfr_route_bank cfr_route_asserts #(.ADDR_W(ADDR_W)) cfr_route_asserts_inst (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .filterAcceptOn(filterAcceptOn), .filterDestObject(filterDestObject));

// ### tb/cfr_route_bank_test.sv
// Purpose: directed test of the filter routing bank
// Assumes: apb master waits for pready
// Notes:   expected words built from the lane layout
`timescale 1ns/1ps
// ============================================================
// bench
module cfr_route_bank_test;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = '0, filterAcceptOn;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0]  pstrb = '0;
  logic [59:0] filterDestObject;
  int          errors = 0, total_checks = 0;

  always #4 clk = ~clk;

  cfr_route_bank cfr_route_bank_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .filterAcceptOn(filterAcceptOn),
    .filterDestObject(filterDestObject));

  task chk(input logic [63:0] g, x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask

  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] x);
    xfer(a, 0, '0, 4'h0);
    chk(r, x);
  endtask

  task summarize;
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task tReset;
    for (int i = 0; i < 3; i++) rd(12'(4 * i), '0);
    chk(filterAcceptOn, '0);
    chk(filterDestObject, '0);
  endtask

  task tFields;
    for (int i = 0; i < 3; i++) begin
      xfer(12'(4 * i), 1, 32'h9fe26381, 4'hf);
      rd(12'(4 * i), 32'h9f820381);
      chk(filterAcceptOn[4*i+:4], 4'hd);
      chk(filterDestObject[20*i+:20], {5'd31, 5'd2, 5'd3, 5'd1});
    end
  endtask

  task tLock;
    xfer(12'h0, 1, 32'h85858585, 4'hf);
    rd(12'h0, 32'h9f828581);
    // pointers kept nonzero throughout
    xfer(12'h0, 1, 32'h03030303, 4'hf);
    rd(12'h0, 32'h1f020501);
    xfer(12'h0, 1, 32'h04040404, 4'hf);
    rd(12'h0, 32'h04040404);
    xfer(12'h0, 1, 32'h1f1f1f1f, 4'h2);
    rd(12'h0, 32'h04041f04);
  endtask

  task tUnmapped;
    rd(12'h010, '0);
    chk(e, 1'b1);
  endtask

  // status word: enables, sticky refused change and its clear
  task tStatus;
    rd(12'h00c, 32'h0001_0dd0);
    chk(e, 1'b0);
    xfer(12'h00c, 1, 32'h0001_0000, 4'h4);
    rd(12'h00c, 32'h0000_0dd0);
  endtask

  // reset in mid-run clears programmed state
  task tMidReset;
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    tReset;
    rd(12'h00c, '0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    tReset;
    tFields;
    tLock;
    tUnmapped;
    tStatus;
    tMidReset;
    summarize;
  end

  initial begin
    #20000;
    errors++;
    summarize;
  end
endmodule // cfr_route_bank_test
